// *** rtl/sled_map.vh ***
// How it works
// - Link indicator green alone when link powered and talking; dark without power.
// - Link indicator red alone when link powered but communication failed.
// - Link indicator green and red together while powered but uninitialised.
// - Module green: single flash reset, blink preop, double flash boot, on run.
// - Module red off without fault, steady on in error or reset condition.
// - Module red single flash on channel warning or output level monitor trip.
// - Module red double flash while encoder or module supply is out of range.
// - Channel indicator orange for output channel state, green for input state.
// - Shared indicator drives orange and green together when one active output and one active input channel share it.
`ifndef SLED_MAP_VH
`define SLED_MAP_VH
`define SLED_CLK_HZ 10000000
`define SLED_SLOT_MS 100
`define SLED_SLOT_CYC ((`SLED_CLK_HZ / 1000) * `SLED_SLOT_MS)
`define SLED_DIV_W 20
`define SLED_INT_W 32
`define SLED_SYNC_W 26
`define SLED_SLOT_W 4
`define SLED_SLOT_LAST 4'hB
`define SLED_MODE_W 2
`define SLED_MODE_RESET 2'h0
`define SLED_MODE_PREOP 2'h1
`define SLED_MODE_BOOT 2'h2
`define SLED_MODE_RUN 2'h3
`define SLED_NCH 8
`define SLED_NIND 4
`define SLED_SLOTS 12
`define SLED_PAT_SINGLE 12'h003
`define SLED_PAT_DOUBLE 12'h01B
`define SLED_PAT_BLINK 12'h333
`define SLED_PAT_ON 12'hFFF
`define SLED_PAT_OFF 12'h000
`endif

// *** rtl/sled_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module sled_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire reset_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** rtl/sled_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "sled_map.vh"
module sled_top #(
  parameter integer SLOT_CYC = `SLED_SLOT_CYC
) (
  input wire clk_i,
  input wire reset_i,
  input wire link_power_i,
  input wire link_comm_ok_i,
  input wire pre_operational_state_i,
  input wire [1:0] module_mode_i,
  input wire module_power_i,
  input wire error_i,
  input wire channel_warning_i,
  input wire level_monitor_trip_i,
  input wire supply_fault_i,
  input wire [7:0] channel_is_output_i,
  input wire [7:0] channel_active_i,
  output reg link_green_o,
  output reg link_red_o,
  output reg module_green_o,
  output reg module_red_o,
  output reg [3:0] chan_orange_o,
  output reg [3:0] chan_green_o
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // All status arrives from other logic or pins of unknown timing, so
  // everything is resynchronised; a two-cycle lag is invisible on an LED.
  localparam SW = `SLED_SYNC_W;
  wire [SW-1:0] raw_w;
  wire [SW-1:0] syn_w;
  wire s_lpwr;
  wire s_lok;
  wire s_preop;
  wire [`SLED_MODE_W-1:0] s_mode;
  wire s_mpwr;
  wire s_err;
  wire s_warn;
  wire s_trip;
  wire s_sup;
  wire [`SLED_NCH-1:0] s_isout;
  wire [`SLED_NCH-1:0] s_act;

  assign raw_w = {link_power_i, link_comm_ok_i, pre_operational_state_i,
                  module_mode_i, module_power_i, error_i,
                  channel_warning_i, level_monitor_trip_i, supply_fault_i,
                  channel_is_output_i, channel_active_i};

  sled_sync #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(raw_w),
    .q_o(syn_w)
  );

  // Unpacking in the same order as the packing keeps the two in step
  // without any hand-counted bit positions.
  assign {s_lpwr, s_lok, s_preop, s_mode, s_mpwr, s_err, s_warn, s_trip,
          s_sup, s_isout, s_act} = syn_w;

  // ---------------------------------------------------------------
  // Pattern time base
  // ---------------------------------------------------------------
  // One slot is a fixed fraction of a 12-slot frame; every pattern is
  // a 12-bit mask over the frame so all repeat with the same period.
  // SLOT_CYC must fit the divider; a small value shortens the frame
  // without changing its shape, which keeps simulations short.
  localparam integer SLOT_END = SLOT_CYC - 1;
  reg [`SLED_DIV_W-1:0] div_r;
  reg [`SLED_DIV_W-1:0] div_nxt;
  reg [`SLED_SLOT_W-1:0] slot_r;
  reg [`SLED_SLOT_W-1:0] slot_nxt;
  wire [`SLED_INT_W-1:0] div_wide;
  wire slot_tick;

  assign div_wide = {{(`SLED_INT_W - `SLED_DIV_W){1'b0}}, div_r};
  assign slot_tick = (div_wide == SLOT_END);

  always @* begin
    div_nxt = div_r + 1'b1;
    slot_nxt = slot_r;
    if (slot_tick) begin
      div_nxt = {`SLED_DIV_W{1'b0}};
      if (slot_r == `SLED_SLOT_LAST)
        slot_nxt = {`SLED_SLOT_W{1'b0}};
      else
        slot_nxt = slot_r + 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      div_r <= {`SLED_DIV_W{1'b0}};
      slot_r <= {`SLED_SLOT_W{1'b0}};
    end else begin
      div_r <= div_nxt;
      slot_r <= slot_nxt;
    end
  end

  function pat_bit;
    input [`SLED_SLOTS-1:0] pat;
    input [`SLED_SLOT_W-1:0] slot;
    begin
      pat_bit = pat[slot];
    end
  endfunction

  // ---------------------------------------------------------------
  // Module indicator pattern selection
  // ---------------------------------------------------------------
  reg [`SLED_SLOTS-1:0] g_pat;
  reg [`SLED_SLOTS-1:0] r_pat;
  reg mg_nxt;
  reg mr_nxt;

  always @* begin
    g_pat = `SLED_PAT_OFF;
    if (s_mpwr) begin
      case (s_mode)
        `SLED_MODE_RESET: g_pat = `SLED_PAT_SINGLE;
        `SLED_MODE_PREOP: g_pat = `SLED_PAT_BLINK;
        `SLED_MODE_BOOT: g_pat = `SLED_PAT_DOUBLE;
        `SLED_MODE_RUN: g_pat = `SLED_PAT_ON;
        default: g_pat = `SLED_PAT_OFF;
      endcase
    end
  end

  // An error outranks a supply fault, which outranks a channel warning,
  // so the most serious condition is the one shown.
  always @* begin
    r_pat = `SLED_PAT_OFF;
    if (s_mpwr) begin
      if (s_err || s_mode == `SLED_MODE_RESET)
        r_pat = `SLED_PAT_ON;
      else if (s_sup)
        r_pat = `SLED_PAT_DOUBLE;
      else if (s_warn || s_trip)
        r_pat = `SLED_PAT_SINGLE;
      else
        r_pat = `SLED_PAT_OFF;
    end
  end

  // A condition change shows at once with the bit of the current slot,
  // so a flash may start part way through; the next frame is whole.
  always @* begin
    mg_nxt = pat_bit(g_pat, slot_r);
    mr_nxt = pat_bit(r_pat, slot_r);
  end

  // ---------------------------------------------------------------
  // Link indicator
  // ---------------------------------------------------------------
  // The uninitialised state outranks the communication flag, because
  // the link may already report good traffic before setup is done.
  reg lg_nxt;
  reg lr_nxt;

  always @* begin
    lg_nxt = 1'b0;
    lr_nxt = 1'b0;
    if (s_lpwr) begin
      if (s_preop) begin
        lg_nxt = 1'b1;
        lr_nxt = 1'b1;
      end else if (s_lok) begin
        lg_nxt = 1'b1;
      end else begin
        lr_nxt = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channel indicators
  // ---------------------------------------------------------------
  // Each indicator is shared by channels 2i and 2i+1; its orange and
  // green elements are independent, so both light when one active
  // output and one active input share it.
  wire [`SLED_NIND-1:0] co_nxt;
  wire [`SLED_NIND-1:0] cg_nxt;

  genvar i;
  generate
    for (i = 0; i < `SLED_NIND; i = i + 1) begin : g_ind
      wire [1:0] act = s_act[2*i+1:2*i];
      wire [1:0] out = s_isout[2*i+1:2*i];
      assign co_nxt[i] = |(act & out);
      assign cg_nxt[i] = |(act & ~out);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Every lamp line leaves from a flip-flop so no decode glitch ever
  // reaches a driver.
  always @(posedge clk_i) begin
    if (reset_i) begin
      link_green_o <= 1'b0;
      link_red_o <= 1'b0;
      module_green_o <= 1'b0;
      module_red_o <= 1'b0;
      chan_orange_o <= {`SLED_NIND{1'b0}};
      chan_green_o <= {`SLED_NIND{1'b0}};
    end else begin
      link_green_o <= lg_nxt;
      link_red_o <= lr_nxt;
      module_green_o <= mg_nxt;
      module_red_o <= mr_nxt;
      chan_orange_o <= co_nxt;
      chan_green_o <= cg_nxt;
    end
  end
endmodule
`default_nettype wire

// *** sim/sled_panel.sv ***
`timescale 1ns/100ps
`default_nettype none
module sled_panel (
  input wire logic [3:0] orange_i,
  input wire logic [3:0] green_i,
  output logic [3:0] mixed_o
);
  // One light guide per indicator, so two lit elements read as a blend.
  assign mixed_o = orange_i & green_i;
endmodule
`default_nettype wire

// *** sim/sled_top_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module sled_chk (
  input wire logic clk_i, reset_i, link_power_i, link_comm_ok_i,
  input wire logic pre_operational_state_i, module_power_i, error_i,
  input wire logic channel_warning_i, level_monitor_trip_i,
  input wire logic supply_fault_i,
  input wire logic [1:0] module_mode_i,
  input wire logic [7:0] channel_is_output_i, channel_active_i,
  input wire logic link_green_o, link_red_o, module_green_o,
  input wire logic module_red_o,
  input wire logic [3:0] chan_orange_o, chan_green_o
);
  // ---------------------------------------------
  // Warm-up: the synchroniser needs edges to fill.
  // ---------------------------------------------
  reg [2:0] up_r;
  wire up = up_r >= 3'h4;
  always @(posedge clk_i) begin
    if (reset_i) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  link_dark_a: assert property (up && !$past(link_power_i, 3) |->
    !link_green_o && !link_red_o) else $error("link lit unpowered");
  link_good_a: assert property (up && $past(link_power_i &&
    link_comm_ok_i && !pre_operational_state_i, 3) |->
    link_green_o && !link_red_o) else $error("link not green");
  link_fail_a: assert property (up && $past(link_power_i &&
    !link_comm_ok_i && !pre_operational_state_i, 3) |->
    link_red_o && !link_green_o) else $error("link not red");
  link_both_a: assert property (up && $past(link_power_i &&
    pre_operational_state_i, 3) |-> link_red_o && link_green_o)
    else $error("link not both");
  mod_dark_a: assert property (up && $past(!module_power_i, 3) |->
    !module_green_o && !module_red_o) else $error("module lit unpowered");
  run_steady_a: assert property (up && $past(module_power_i &&
    module_mode_i == 2'h3, 3) |-> module_green_o) else $error("run dark");
  red_steady_a: assert property (up && $past(module_power_i &&
    error_i, 3) |-> module_red_o) else $error("error red dark");
  red_quiet_a: assert property (up && $past(!error_i &&
    !supply_fault_i && !channel_warning_i && !level_monitor_trip_i &&
    module_mode_i != 2'h0, 3) |-> !module_red_o)
    else $error("red lit without fault");
  chan_mix_a: assert property (up |-> chan_orange_o[0] ==
    $past(|(channel_active_i[1:0] & channel_is_output_i[1:0]), 3) &&
    chan_green_o[0] == $past(|(channel_active_i[1:0] &
    ~channel_is_output_i[1:0]), 3)) else $error("channel led wrong");
  cover property (link_green_o && link_red_o);
  cover property (module_red_o && module_green_o);
  cover property (chan_orange_o[0] && chan_green_o[0]);
  cover property (module_red_o ##1 !module_red_o);
endmodule
bind sled_top sled_chk sled_chk_i (.*);
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int SLOT = 4;
  localparam int LIMIT = 3000;
  logic clk_i = 0, reset_i = 1, lp = 0, ok = 0, pre = 0, mp = 0, er = 0;
  logic wn = 0, tr = 0, sf = 0;
  logic [1:0] md = 2'h0;
  logic [7:0] co = 8'h00, ca = 8'h00;
  logic [31:0] seed = 32'h00015471;
  logic [11:0] w, seen;
  wire lg, lr, mg, mr;
  wire [3:0] oro, gro, mix;
  int err_count = 0, compares = 0, cyc = 0, pe = 0, i;
  logic [11:0] q[$];
  event got;
  always #50 clk_i = ~clk_i;
  sled_top #(.SLOT_CYC(SLOT)) sled_top_i (.clk_i(clk_i), .reset_i(reset_i),
    .link_power_i(lp), .link_comm_ok_i(ok), .pre_operational_state_i(pre),
    .module_mode_i(md), .module_power_i(mp), .error_i(er),
    .channel_warning_i(wn), .level_monitor_trip_i(tr), .supply_fault_i(sf),
    .channel_is_output_i(co), .channel_active_i(ca), .link_green_o(lg),
    .link_red_o(lr), .module_green_o(mg), .module_red_o(mr),
    .chan_orange_o(oro), .chan_green_o(gro));
  sled_panel sled_panel_i (.orange_i(oro), .green_i(gro), .mixed_o(mix));
  // ------------------------------------------------------------
  // Expected lamps for slot s of the 12-slot pattern frame.
  // ------------------------------------------------------------
  function automatic logic [11:0] exp_f(input int s);
    logic [11:0] e, gp, rp;
    gp = md == 2'h0 ? 12'h003 : md == 2'h1 ? 12'h333 :
      md == 2'h2 ? 12'h01B : 12'hFFF;
    rp = (er | md == 2'h0) ? 12'hFFF : sf ? 12'h01B :
      (wn | tr) ? 12'h003 : 12'h000;
    e[11] = lp & (pre | ok);
    e[10] = lp & (pre | ~ok);
    e[9] = mp & gp[s];
    e[8] = mp & rp[s];
    for (int k = 0; k < 4; k++) begin
      e[4+k] = |(ca[2*k+:2] & co[2*k+:2]);
      e[k] = |(ca[2*k+:2] & ~co[2*k+:2]);
    end
    return e;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task check(input string n, input logic [11:0] s, input logic [11:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(got) begin
    w = q.pop_front();
    seen = {lg, lr, mg, mr, oro, gro};
    check("link", seen & 12'hC00, w & 12'hC00);
    check("mod_green", seen & 12'h200, w & 12'h200);
    check("mod_red", seen & 12'h100, w & 12'h100);
    check("chan", seen & 12'h0FF, w & 12'h0FF);
    check("panel", {8'h00, mix}, {8'h00, w[7:4] & w[3:0]});
  end
  always @(posedge clk_i) begin
    cyc++;
    if (!reset_i) pe++;
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(negedge clk_i);
    reset_i = 0;
    for (i = 0; i < 240; i++) begin
      seed = xs(seed);
      {lp, ok, pre, mp, er, wn, tr, sf, md} = seed[9:0];
      {co, ca} = seed[25:10];
      repeat (5) @(negedge clk_i);
      q.push_back(exp_f(((pe - 1) / SLOT) % 12));
      -> got;
    end
    #1 print_verdict;
  end
endmodule
`default_nettype wire
